// [dv/hbav_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module hbav_host_model (
	input  wire logic clk_in,
	input  wire logic reset_in,
	input  wire logic bus_request_in,
	output logic      grant_out
);
	logic [1:0] cnt;
	logic [1:0] next_cnt;
	logic       next_grant;

	// grants a pending request and holds the acknowledge for four cycles
	always_comb begin
		next_grant = grant_out;
		next_cnt = cnt;
		if (!grant_out && bus_request_in) begin
			next_grant = 1'b1;
			next_cnt = 2'h0;
		end else if (grant_out) begin
			next_cnt = cnt + 2'h1;
			if (cnt == 2'h3)
				next_grant = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			grant_out <= 1'b0;
			cnt <= 2'h0;
		end else begin
			grant_out <= next_grant;
			cnt <= next_cnt;
		end
	end
endmodule

`default_nettype wire

// [dv/hbav_top_test.sv]
`timescale 1ns/1ps
`default_nettype none

module hbav_top_test;
	logic        clk, rst, init, cyc, inh, lock, clr, set, mop, ev_in, ev_out, grant;
	logic [17:0] addr;
	logic [9:0]  asw;
	logic [5:0]  vsw;
	logic        sel_v, run, maint, req, oe_n, done;
	logic [2:0]  sel, lvl;
	logic [8:0]  vec;
	int          mismatches;
	int          checks;

	hbav_top DUT (.clk_in(clk), .reset_in(rst), .bus_init_in(init), .addr_in(addr), .bus_cycle_in(cyc),
		.addr_switch_closed_in(asw), .vec_switch_closed_in(vsw), .microcode_exec_inhibit_in(inh),
		.maintenance_lockout_in(lock), .host_run_clear_in(clr), .host_run_set_in(set),
		.host_maint_op_in(mop), .input_request_interrupt_in(ev_in), .output_ready_interrupt_in(ev_out),
		.grant_in(grant), .reg_select_valid_out(sel_v), .reg_select_out(sel), .run_out(run),
		.maint_enable_out(maint), .bus_request_out(req), .bus_request_level_out(lvl),
		.vec_data_out(vec), .vec_data_oe_n_out(oe_n), .ack_done_out(done));

	hbav_host_model host (.clk_in(clk), .reset_in(rst), .bus_request_in(req), .grant_out(grant));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	task automatic check(input string n, input logic [8:0] s, input logic [8:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// w 0: wait for the vector to be driven, w 1: wait for the done pulse
	task automatic wait_on(input int w);
		int i;
		for (i = 0; i < 30 && ((w == 0) ? oe_n : !done) !== 1'b0; i++)
			step();
		if (((w == 0) ? oe_n : !done) !== 1'b0) begin
			mismatches++;
			stop_test();
		end
	endtask

	// select stands for one cycle after the matched address, so look right after it
	task automatic access(input logic [17:0] a, input logic exp_v);
		addr = a;
		cyc = 1'b1;
		step();
		cyc = 1'b0;
		check("select valid", {8'h00, sel_v}, {8'h00, exp_v});
		if (exp_v)
			check("select", {6'h00, sel}, {6'h00, a[2:0]});
		step();
	endtask

	task automatic address_decode();
		asw = 10'h3f0;
		access(18'h3e07d, 1'b1);
		access(18'h3e078, 1'b1);
		access(18'h3c07d, 1'b0);
		access(18'h3e075, 1'b0);
		access(18'h3e0fd, 1'b0);
	endtask

	task automatic both_interrupts();
		vsw = 6'h0c;
		ev_in = 1'b1;
		ev_out = 1'b1;
		step();
		ev_in = 1'b0;
		ev_out = 1'b0;
		check("vector idle", {8'h00, oe_n}, 9'h001);
		step();
		check("request", {8'h00, req}, 9'h001);
		wait_on(0);
		check("level", {6'h00, lvl}, 9'h005);
		check("input vector", vec, 9'h060);
		wait_on(1);
		check("done", {8'h00, done}, 9'h001);
		step();
		check("released", {8'h00, oe_n}, 9'h001);
		wait_on(0);
		check("output vector", vec, 9'h064);
	endtask

	task automatic run_control();
		check("run after reset", {8'h00, run}, 9'h001);
		inh = 1'b1;
		init = 1'b1;
		step();
		step();
		check("inhibit", {8'h00, run}, 9'h000);
		inh = 1'b0;
		step();
		init = 1'b0;
		step();
		check("init", {8'h00, run}, 9'h001);
		lock = 1'b1;
		mop = 1'b1;
		clr = 1'b1;
		step();
		clr = 1'b0;
		step();
		check("maint locked", {8'h00, maint}, 9'h000);
		check("host clear", {8'h00, run}, 9'h000);
		set = 1'b1;
		step();
		set = 1'b0;
		step();
		check("set locked", {8'h00, run}, 9'h000);
		lock = 1'b0;
		step();
		check("maint open", {8'h00, maint}, 9'h001);
		set = 1'b1;
		step();
		set = 1'b0;
		step();
		check("host set", {8'h00, run}, 9'h001);
	endtask

	initial begin
		{rst, init, cyc, inh, lock, clr, set, mop, ev_in, ev_out} = 10'h200;
		addr = 18'h00000;
		asw = 10'h000;
		vsw = 6'h00;
		mismatches = 0;
		checks = 0;
		repeat (6) step();
		rst = 1'b0;
		run_control();
		address_decode();
		both_interrupts();
		repeat (10) step();
		stop_test();
	end
endmodule

`default_nettype wire

// [hdl/hbav_addr_match.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hbav_cfg.svh"

module hbav_addr_match (
	input  wire logic [`HBAV_ADDR_W-1:0] addr_in,
	input  wire logic [`HBAV_CMP_N-1:0]  addr_switch_closed_in,
	output logic                         match_out
);
	logic [`HBAV_CMP_N-1:0] bit_ok;

	genvar i;
	generate
		for (i = 0; i < `HBAV_CMP_N; i = i + 1) begin : g_cmp
			// closed switch wants zero, open switch wants one
			assign bit_ok[i] = addr_in[`HBAV_CMP_LO + i] == ~addr_switch_closed_in[i]; // [R2] [R3]
		end
	endgenerate

	// floating region: upper bits always one, no switch involved
	assign match_out = (&addr_in[`HBAV_FLOAT_HI:`HBAV_FLOAT_LO]) && (&bit_ok); // [R1]
endmodule

`default_nettype wire

// [hdl/hbav_cfg.svh]
`ifndef HBAV_CFG_SVH
`define HBAV_CFG_SVH

`define HBAV_ADDR_W        18
`define HBAV_FLOAT_LO      13
`define HBAV_FLOAT_HI      17
`define HBAV_CMP_LO        3
`define HBAV_CMP_HI        12
`define HBAV_CMP_N         10
`define HBAV_SEL_W         3
`define HBAV_VEC_W         9
`define HBAV_VEC_SW_LO     3
`define HBAV_VEC_SW_N      6
`define HBAV_VEC_SRC_BIT   2
`define HBAV_BR_LEVEL_RST  3'h5

`endif

// [hdl/hbav_pkg.sv]
`default_nettype none

package hbav_pkg;
	typedef enum logic {
		HBAV_SRC_INPUT,
		HBAV_SRC_OUTPUT
	} hbav_src_t;

	typedef enum logic [1:0] {
		HBAV_IDLE,
		HBAV_REQ,
		HBAV_ACK
	} hbav_irq_state_t;
endpackage

`default_nettype wire

// [hdl/hbav_top.sv]
// Notes on behaviour
// [R1] Address bits 13 to 17 must all be one; no switch compares them.
// [R2] Address bits 3 to 12 are compared against ten address switches.
// [R3] Closed switch requires zero on its address line; open switch requires one.
// [R4] On a block match the low three address bits select one of eight registers.
// [R5] Vector goes on data bits 0 to 8; bits 0 and 1 are zero.
// [R6] Input request vector ends in octal 0, output ready in octal 4.
// [R7] Vector bit 2 follows the interrupt source being serviced.
// [R8] Vector bits 3 to 8 from six switches: open gives zero, closed gives one.
// [R9] Initialization sets the run flip-flop so microcode starts at once.
// [R10] Closed run-inhibit switch holds the run flip-flop cleared.
// [R11] Closed lockout switch disables maintenance, host may still clear run.
// [R12] Interrupts are requested at bus level 5 by default, set by a plug.
// [R13] Vector is driven only during the acknowledge granting our request.
`timescale 1ns/1ps
`default_nettype none
`include "hbav_cfg.svh"

module hbav_top #(
	parameter logic [2:0] BR_LEVEL = `HBAV_BR_LEVEL_RST
) (
	input  wire logic                        clk_in,
	input  wire logic                        reset_in,
	input  wire logic                        bus_init_in,
	input  wire logic [`HBAV_ADDR_W-1:0]     addr_in,
	input  wire logic                        bus_cycle_in,
	input  wire logic [`HBAV_CMP_N-1:0]      addr_switch_closed_in,
	input  wire logic [`HBAV_VEC_SW_N-1:0]   vec_switch_closed_in,
	input  wire logic                        microcode_exec_inhibit_in,
	input  wire logic                        maintenance_lockout_in,
	input  wire logic                        host_run_clear_in,
	input  wire logic                        host_run_set_in,
	input  wire logic                        host_maint_op_in,
	input  wire logic                        input_request_interrupt_in,
	input  wire logic                        output_ready_interrupt_in,
	input  wire logic                        grant_in,
	output logic                             reg_select_valid_out,
	output logic [`HBAV_SEL_W-1:0]           reg_select_out,
	output logic                             run_out,
	output logic                             maint_enable_out,
	output logic                             bus_request_out,
	output logic [2:0]                       bus_request_level_out,
	output logic [`HBAV_VEC_W-1:0]           vec_data_out,
	output logic                             vec_data_oe_n_out,
	output logic                             ack_done_out
);
	logic                   match;
	logic                   run;
	logic                   next_run;
	logic                   sel_valid;
	logic                   next_sel_valid;
	logic [`HBAV_SEL_W-1:0] sel;
	logic [`HBAV_SEL_W-1:0] next_sel;
	logic                   pend_in;
	logic                   next_pend_in;
	logic                   pend_out;
	logic                   next_pend_out;
	hbav_pkg::hbav_irq_state_t state;
	hbav_pkg::hbav_irq_state_t next_state;
	hbav_pkg::hbav_src_t    src;
	hbav_pkg::hbav_src_t    next_src;
	logic [`HBAV_VEC_W-1:0] vec;
	logic [`HBAV_VEC_W-1:0] next_vec;
	logic                   vec_oe_n;
	logic                   next_vec_oe_n;
	logic                   done;
	logic                   next_done;

	hbav_addr_match u_match (
		.addr_in               (addr_in),
		.addr_switch_closed_in (addr_switch_closed_in),
		.match_out             (match)
	);

	// register select
	always_comb begin
		next_sel_valid = bus_cycle_in && match;
		next_sel = addr_in[`HBAV_SEL_W-1:0]; // [R4]
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			sel_valid <= 1'b0;
			sel <= 3'h0;
		end else begin
			sel_valid <= next_sel_valid;
			sel <= next_sel;
		end
	end

	// run flip-flop: inhibit dominates, then init sets, then host writes
	always_comb begin
		next_run = run;
		if (microcode_exec_inhibit_in)
			next_run = 1'b0; // [R10]
		else if (bus_init_in)
			next_run = 1'b1; // [R9]
		else if (host_run_clear_in)
			next_run = 1'b0; // [R11]
		else if (host_run_set_in && !maintenance_lockout_in)
			next_run = 1'b1;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in)
			run <= 1'b1; // [R9]
		else
			run <= next_run;
	end

	// interrupt request and vector
	always_comb begin
		next_pend_in = pend_in || input_request_interrupt_in;
		next_pend_out = pend_out || output_ready_interrupt_in;
		next_state = state;
		next_src = src;
		next_vec = vec;
		next_vec_oe_n = 1'b1;
		next_done = 1'b0;
		unique case (state)
			hbav_pkg::HBAV_IDLE: begin
				if (pend_in) begin
					next_src = hbav_pkg::HBAV_SRC_INPUT;
					next_state = hbav_pkg::HBAV_REQ;
				end else if (pend_out) begin
					next_src = hbav_pkg::HBAV_SRC_OUTPUT;
					next_state = hbav_pkg::HBAV_REQ;
				end
			end
			hbav_pkg::HBAV_REQ: begin
				if (grant_in) begin
					next_vec = {vec_switch_closed_in, // [R8]
						src == hbav_pkg::HBAV_SRC_OUTPUT, 2'b00}; // [R5] [R6] [R7]
					next_vec_oe_n = 1'b0; // [R13]
					next_state = hbav_pkg::HBAV_ACK;
				end
			end
			hbav_pkg::HBAV_ACK: begin
				if (grant_in) begin
					next_vec_oe_n = 1'b0; // [R13]
				end else begin
					next_vec = 9'h000;
					next_done = 1'b1;
					next_state = hbav_pkg::HBAV_IDLE;
					if (src == hbav_pkg::HBAV_SRC_INPUT)
						next_pend_in = input_request_interrupt_in;
					else
						next_pend_out = output_ready_interrupt_in;
				end
			end
			default: next_state = hbav_pkg::HBAV_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pend_in <= 1'b0;
			pend_out <= 1'b0;
			state <= hbav_pkg::HBAV_IDLE;
			src <= hbav_pkg::HBAV_SRC_INPUT;
			vec <= 9'h000;
			vec_oe_n <= 1'b1;
			done <= 1'b0;
		end else begin
			pend_in <= next_pend_in;
			pend_out <= next_pend_out;
			state <= next_state;
			src <= next_src;
			vec <= next_vec;
			vec_oe_n <= next_vec_oe_n;
			done <= next_done;
		end
	end

	assign reg_select_valid_out = sel_valid;
	assign reg_select_out = sel;
	assign run_out = run;
	assign maint_enable_out = !maintenance_lockout_in && host_maint_op_in; // [R11]
	assign bus_request_out = state == hbav_pkg::HBAV_REQ;
	assign bus_request_level_out = BR_LEVEL; // [R12]
	assign vec_data_out = vec;
	assign vec_data_oe_n_out = vec_oe_n;
	assign ack_done_out = done;

	decode_select_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R4]
		(bus_cycle_in && match) |=> (sel_valid && sel == $past(addr_in[2:0])))
		else $error("register select wrong after match");
	float_bits_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R1]
		(bus_cycle_in && addr_in[17:13] != 5'h1f) |=> !sel_valid)
		else $error("selected outside floating region");
	vec_low_zero_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R5]
		!vec_oe_n |-> vec[1:0] == 2'b00)
		else $error("vector low bits not zero");
	vec_src_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R6]
		!vec_oe_n |-> vec[2] == (src == hbav_pkg::HBAV_SRC_OUTPUT))
		else $error("vector bit 2 does not match source");
	vec_switch_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R8]
		(state == hbav_pkg::HBAV_REQ && grant_in) |=> vec[8:3] == $past(vec_switch_closed_in))
		else $error("vector upper bits not from switches");
	vec_release_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R13]
		(state == hbav_pkg::HBAV_ACK && !grant_in) |=> vec_oe_n && done)
		else $error("vector not released after acknowledge");
	vec_only_grant_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R13]
		!vec_oe_n |-> $past(grant_in))
		else $error("vector driven without grant");
	inhibit_run_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R10]
		microcode_exec_inhibit_in |=> !run)
		else $error("run not cleared under inhibit");
	init_run_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R9]
		(bus_init_in && !microcode_exec_inhibit_in) |=> run)
		else $error("run not set by initialization");
	lockout_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R11]
		maintenance_lockout_in |-> !maint_enable_out)
		else $error("maintenance active under lockout");
	host_clear_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R11]
		(host_run_clear_in && !bus_init_in) |=> !run)
		else $error("host clear of run ignored");
endmodule

`default_nettype wire
